/* File: include/gpt_pkg.sv */
// constants, field layout and types shared by the general timer module
package gpt_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_MODE_A = 8'h04;
	localparam logic [7:0] OFS_MODE_B = 8'h08;
	localparam logic [7:0] OFS_CTL = 8'h0C;
	localparam logic [7:0] OFS_IMR = 8'h18;
	localparam logic [7:0] OFS_RIS = 8'h1C;
	localparam logic [7:0] OFS_MIS = 8'h20;
	localparam logic [7:0] OFS_ICR = 8'h24;
	localparam logic [7:0] OFS_ILR_A = 8'h28;
	localparam logic [7:0] OFS_ILR_B = 8'h2C;
	localparam logic [7:0] OFS_MATCH_A = 8'h30;
	localparam logic [7:0] OFS_MATCH_B = 8'h34;
	localparam logic [7:0] OFS_PR_A = 8'h38;
	localparam logic [7:0] OFS_PR_B = 8'h3C;
	localparam logic [7:0] OFS_CNT_A = 8'h48;
	localparam logic [7:0] OFS_CNT_B = 8'h4C;

	// ==========================================================
	// configuration codes
	typedef enum logic [2:0]
	{
		CFG_JOINED = 3'h0,
		CFG_RTC = 3'h1,
		CFG_SPLIT = 3'h4
	} gpt_cfg_e;

	// timer mode field codes, capture-mode bit position
	localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
	localparam logic [1:0] MODE_PERIODIC = 2'h2;
	localparam logic [1:0] MODE_EDGE = 2'h3;
	localparam int MODE_CMR_BIT = 2;

	// ==========================================================
	// control bits of timer a; timer b sits TB_SHIFT bits higher
	localparam int TB_SHIFT = 8;
	localparam int CTL_EN = 0;
	localparam int CTL_STALL = 1;
	localparam int CTL_EVENT = 2;
	localparam int CTL_RTC_OVR = 4;
	localparam int CTL_OTE = 5;

	// edge select codes
	localparam logic [1:0] EVT_RISE = 2'h0;
	localparam logic [1:0] EVT_FALL = 2'h1;

	// status bits of timer a; timer b sits TB_SHIFT bits higher
	localparam int ST_TIMEOUT = 0;
	localparam int ST_EDGE_MATCH = 1;
	localparam int ST_CLOCK_MATCH = 3;

	// ==========================================================
	// reset values and fixed counts
	localparam logic [15:0] CNT_RST = 16'hFFFF;
	localparam logic [15:0] ILR_RST = 16'hFFFF;
	localparam logic [7:0] PR_RST = 8'h00;
	localparam logic [31:0] RTC_FIRST = 32'h0000_0001;
	localparam int RTC_IN_HZ = 32768;
	localparam int RTC_OUT_HZ = 1;
	localparam int RTC_DIV_DFLT = RTC_IN_HZ / RTC_OUT_HZ;

endpackage : gpt_pkg

/* File: hw/gpt_timer.sv */
// general timer module: joined 32-bit, real-time clock and split 16-bit timers
//
// Overview of operation
// R1: config 0 joined timer, 1 real-time clock
// R2: config 4 splits into two 16-bit timers
// R3: joined load write fills both halves
// R4: joined count read gives b:a halves
// R5: joined timer counts down, reloads after zero
// R6: one-shot stops and clears enable; periodic continues
// R7: mode field 1 one-shot, 2 periodic
// R8: zero sets timeout raw flag, masked if enabled
// R9: one-cycle trigger pulse at zero if enabled
// R10: load rewrite takes effect next cycle
// R11: stall bit freezes the count
// R12: clock mode counts up, first load one
// R13: 32.768 kHz pin divided to 1 Hz
// R14: clock match rolls count to zero
// R15: clock match sets raw and masked flags
// R16: stall override keeps clock counter running
// R17: split timer 16-bit down with 8-bit prescaler
// R18: split timer reloads load and prescale after zero
// R19: split timeout sets raw and masked flags
// R20: prescale p gives p+1 clocks per count
// R21: edge count mode counts selected edges down
// R22: software clears capture bit, sets match
// R23: mode field 3 selects edge count
// R24: edge decrements; at match flag, reload, disable
// R25: edges ignored until enable set again
// R26: reset counters and loads all ones
// R27: split uses both pins, joined even only
// R28: pins synchronised and edge detected
module gpt_timer
	import gpt_pkg::*;
#(
	parameter int RTC_DIV = RTC_DIV_DFLT
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic capture_pin_even,
	input wire logic capture_pin_odd,
	output logic [31:0] rd_data,
	output logic trig_a,
	output logic trig_b,
	output logic irq
);

	// ==========================================================
	// state
	// a divider of one still keeps a one-bit counter so the struct stays legal
	localparam int DIVW = (RTC_DIV > 1) ? $clog2(RTC_DIV) : 1;

	typedef struct packed
	{
		logic [2:0] cfg; // timer_configuration
		logic [1:0][2:0] mode; // timer_n_mode_register
		logic [15:0] ctl; // timer_control
		logic [15:0] imr; // interrupt_mask
		logic [15:0] ris; // raw_interrupt_status
		logic [1:0][15:0] ilr; // timer_n_interval_load
		logic [1:0][15:0] match; // timer_n_match
		logic [1:0][7:0] pr; // timer_n_prescale
		logic [1:0][15:0] cnt; // timer count halves
		logic [1:0][7:0] ps; // prescale down-counters
		logic [DIVW-1:0] div; // real-time clock input divider
		logic [2:0] sync_e; // even pin: two sync stages and a delay
		logic [2:0] sync_o; // odd pin: two sync stages and a delay
		logic [31:0] rd_data; // read data, valid one cycle after strobe
		logic [1:0] trig; // trigger pulses
		logic irq; // any masked status bit
	} gpt_state_s;

	gpt_state_s state_reg;
	gpt_state_s state_next;

	// ==========================================================
	// helpers

	// picks the edges that the event field asks for; codes past falling count both
	function automatic logic edge_hit(input logic [1:0] evt, input logic rise, input logic fall);
		logic hit;
		hit = rise | fall;
		if (evt == EVT_RISE)
			hit = rise;
		else if (evt == EVT_FALL)
			hit = fall;
		return hit;
	endfunction : edge_hit

	// one bit of a timer's control or status word
	function automatic int tbit(input int t, input int b);
		return t * TB_SHIFT + b;
	endfunction : tbit

	// ==========================================================
	// next-state logic
	logic [31:0] c32; // joined count
	logic [31:0] n32; // joined count after one step
	logic [31:0] ilr32; // joined load value
	logic [31:0] match32; // joined match value
	logic [1:0] rise; // synchronised rising edges
	logic [1:0] fall; // synchronised falling edges
	logic [15:0] sets; // status bits raised this cycle
	logic [15:0] clr; // status bits cleared by software
	logic [15:0] dec; // decremented half
	logic split; // split 16-bit configuration
	logic [1:0] md; // mode field of the timer in hand
	logic rtc_run; // clock counter may advance

	always_comb
	begin
		state_next = state_reg;
		sets = '0;
		clr = '0;
		dec = '0;
		md = '0;
		// triggers fall back low unless set again, so each pulse lasts one cycle
		state_next.trig = 2'b00;
		c32 = {state_reg.cnt[1], state_reg.cnt[0]};
		n32 = c32;
		ilr32 = {state_reg.ilr[1], state_reg.ilr[0]};
		match32 = {state_reg.match[1], state_reg.match[0]};
		// the halves run apart only under the split code; every other code pairs them
		split = (state_reg.cfg == CFG_SPLIT);

		// pins pass two flops; only the second and the delay stage feed edges
		state_next.sync_e = {state_reg.sync_e[1:0], capture_pin_even}; // R28
		state_next.sync_o = {state_reg.sync_o[1:0], capture_pin_odd}; // R28
		rise[0] = state_reg.sync_e[1] & ~state_reg.sync_e[2]; // R28
		fall[0] = ~state_reg.sync_e[1] & state_reg.sync_e[2];
		// odd pin serves timer b only when the halves are split
		rise[1] = split & state_reg.sync_o[1] & ~state_reg.sync_o[2]; // R27
		fall[1] = split & ~state_reg.sync_o[1] & state_reg.sync_o[2]; // R27

		rtc_run = state_reg.ctl[tbit(0, CTL_EN)] &
			(state_reg.ctl[CTL_RTC_OVR] |
			~(state_reg.ctl[tbit(0, CTL_STALL)] | state_reg.ctl[tbit(1, CTL_STALL)])); // R16

		unique case (state_reg.cfg)
			// joined down-counter driven by timer a's controls
			CFG_JOINED:
			begin
				if (state_reg.ctl[tbit(0, CTL_EN)] && !state_reg.ctl[tbit(0, CTL_STALL)]) // R11
				begin
					if (c32 == 32'h0000_0000)
					begin
						// a load of zero lands here every cycle and never flags a time-out
						n32 = ilr32; // R5
						// one-shot only stops once the zero state has been held a cycle
						if (state_reg.mode[0][1:0] != MODE_PERIODIC) // R7
							state_next.ctl[tbit(0, CTL_EN)] = 1'b0; // R6
					end
					else
					begin
						n32 = c32 - 32'h0000_0001; // R5
						if (n32 == 32'h0000_0000)
						begin
							sets[tbit(0, ST_TIMEOUT)] = 1'b1; // R8
							state_next.trig[0] = state_reg.ctl[tbit(0, CTL_OTE)]; // R9
						end
					end
				end
			end

			// joined up-counter fed by the divided even pin
			CFG_RTC:
			begin
				// only rising edges advance the divider, so the reference duty cycle is free
				if (rtc_run && rise[0]) // R13
				begin
					if (state_reg.div == DIVW'(RTC_DIV - 1))
					begin
						state_next.div = '0;
						if (c32 == match32)
						begin
							n32 = 32'h0000_0000; // R14
							sets[ST_CLOCK_MATCH] = 1'b1; // R15
						end
						else
							n32 = c32 + 32'h0000_0001; // R12
					end
					else
						state_next.div = state_reg.div + DIVW'(1); // R13
				end
			end

			// two independent halves
			CFG_SPLIT:
			begin
				for (int t = 0; t < 2; t++)
				begin
					md = state_reg.mode[t][1:0];
					dec = state_reg.cnt[t] - 16'h0001;
					if (md == MODE_EDGE && !state_reg.mode[t][MODE_CMR_BIT]) // R23
					begin
						// with enable low every edge is dropped
						// stall is not looked at: edges come from outside and cannot wait
						if (state_reg.ctl[tbit(t, CTL_EN)] &&
							edge_hit(state_reg.ctl[tbit(t, CTL_EVENT) +: 2], rise[t], fall[t])) // R21
						begin
							state_next.cnt[t] = dec; // R24
							if (dec == state_reg.match[t]) // R22
							begin
								sets[tbit(t, ST_EDGE_MATCH)] = 1'b1; // R24
								state_next.cnt[t] = state_reg.ilr[t]; // R24
								state_next.ctl[tbit(t, CTL_EN)] = 1'b0; // R25
							end
						end
					end
					else if (state_reg.ctl[tbit(t, CTL_EN)] &&
						!state_reg.ctl[tbit(t, CTL_STALL)]) // R11
					begin
						if (state_reg.cnt[t] == 16'h0000)
						begin
							state_next.cnt[t] = state_reg.ilr[t]; // R18
							state_next.ps[t] = state_reg.pr[t]; // R18
							if (md != MODE_PERIODIC) // R7
								state_next.ctl[tbit(t, CTL_EN)] = 1'b0; // R6
						end
						else if (state_reg.ps[t] != 8'h00)
							state_next.ps[t] = state_reg.ps[t] - 8'h01; // R20
						else
						begin
							// prescaler expired: one count per p+1 clocks
							state_next.ps[t] = state_reg.pr[t]; // R20
							state_next.cnt[t] = dec; // R17
							if (dec == 16'h0000)
							begin
								sets[tbit(t, ST_TIMEOUT)] = 1'b1; // R19
								state_next.trig[t] = state_reg.ctl[tbit(t, CTL_OTE)]; // R9
							end
						end
					end
				end
			end

			// unknown configuration codes leave the counters idle
			default:
			begin
				n32 = c32;
			end
		endcase

		// joined modes pair the halves into one counter
		if (!split)
		begin
			state_next.cnt[1] = n32[31:16]; // R1
			state_next.cnt[0] = n32[15:0]; // R1
		end

		// ======================================================
		// register writes; software wins over hardware on control bits
		if (wr_en)
		begin
			unique case (addr)
				OFS_CFG:
				begin
					state_next.cfg = wr_data[2:0]; // R2
					// entering clock mode starts from one and a fresh divider
					if (wr_data[2:0] == CFG_RTC && state_reg.cfg != CFG_RTC)
					begin
						state_next.cnt[1] = RTC_FIRST[31:16]; // R12
						state_next.cnt[0] = RTC_FIRST[15:0]; // R12
						state_next.div = '0;
					end
				end
				OFS_MODE_A: state_next.mode[0] = wr_data[2:0];
				OFS_MODE_B: state_next.mode[1] = wr_data[2:0];
				// a software write beats the hardware enable clear of the same cycle
				OFS_CTL: state_next.ctl = wr_data[15:0];
				OFS_IMR: state_next.imr = wr_data[15:0];
				OFS_ICR: clr = wr_data[15:0];
				OFS_ILR_A:
				begin
					state_next.ilr[0] = wr_data[15:0]; // R3
					if (!split)
						state_next.ilr[1] = wr_data[31:16]; // R3
					// under the joined and split codes a new load value is picked up by the counter at once
					if (state_reg.cfg == CFG_JOINED)
					begin
						state_next.cnt[0] = wr_data[15:0]; // R10
						state_next.cnt[1] = wr_data[31:16]; // R10
					end
					else if (split)
						state_next.cnt[0] = wr_data[15:0]; // R10
				end
				OFS_ILR_B:
				begin
					state_next.ilr[1] = wr_data[15:0];
					if (split)
						state_next.cnt[1] = wr_data[15:0]; // R10
				end
				OFS_MATCH_A:
				begin
					state_next.match[0] = wr_data[15:0];
					if (!split)
						state_next.match[1] = wr_data[31:16]; // R12
				end
				OFS_MATCH_B: state_next.match[1] = wr_data[15:0];
				OFS_PR_A: state_next.pr[0] = wr_data[7:0];
				OFS_PR_B: state_next.pr[1] = wr_data[7:0];
				default:
				begin
					// writes to other offsets are ignored
					clr = '0;
				end
			endcase
		end

		// a flag raised in the clearing cycle survives
		state_next.ris = (state_reg.ris & ~clr) | sets; // R8
		// built from the next state so the interrupt rises together with its flag
		state_next.irq = |(state_next.ris & state_next.imr); // R15

		// ======================================================
		// read data stands only in the cycle after the strobe
		state_next.rd_data = 32'h0000_0000;
		if (rd_en)
		begin
			unique case (addr)
				OFS_CFG: state_next.rd_data = {29'h0, state_reg.cfg};
				OFS_MODE_A: state_next.rd_data = {29'h0, state_reg.mode[0]};
				OFS_MODE_B: state_next.rd_data = {29'h0, state_reg.mode[1]};
				OFS_CTL: state_next.rd_data = {16'h0, state_reg.ctl};
				OFS_IMR: state_next.rd_data = {16'h0, state_reg.imr};
				OFS_RIS: state_next.rd_data = {16'h0, state_reg.ris}; // R8
				OFS_MIS: state_next.rd_data = {16'h0, state_reg.ris & state_reg.imr}; // R19
				OFS_ILR_A:
					state_next.rd_data = split ? {16'h0, state_reg.ilr[0]} : ilr32;
				OFS_ILR_B: state_next.rd_data = {16'h0, state_reg.ilr[1]};
				OFS_MATCH_A:
					state_next.rd_data = split ? {16'h0, state_reg.match[0]} : match32;
				OFS_MATCH_B: state_next.rd_data = {16'h0, state_reg.match[1]};
				OFS_PR_A: state_next.rd_data = {24'h0, state_reg.pr[0]};
				OFS_PR_B: state_next.rd_data = {24'h0, state_reg.pr[1]};
				OFS_CNT_A:
					state_next.rd_data = split ? {16'h0, state_reg.cnt[0]} : c32; // R4
				OFS_CNT_B: state_next.rd_data = {16'h0, state_reg.cnt[1]};
				default:
				begin
					// unmapped offsets read as zero
					state_next.rd_data = 32'h0000_0000;
				end
			endcase
		end
	end

	// ==========================================================
	// state register
	// counts and loads come up all ones, so an unloaded timer runs its longest period
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= '0;
			state_reg.cnt <= {CNT_RST, CNT_RST}; // R26
			state_reg.ilr <= {ILR_RST, ILR_RST}; // R26
			state_reg.pr <= {PR_RST, PR_RST}; // R26
			state_reg.ps <= {PR_RST, PR_RST}; // R26
		end
		else
			state_reg <= state_next;
	end

	// ==========================================================
	// outputs straight from the state register
	assign rd_data = state_reg.rd_data;
	assign trig_a = state_reg.trig[0];
	assign trig_b = state_reg.trig[1];
	assign irq = state_reg.irq;

endmodule : gpt_timer

/* File: sim/gpt_timer_props.sv */
// port-level checker for the general timer module, bound to its top
module gpt_timer_props
	import gpt_pkg::*;
#(
	parameter int RTC_DIV = RTC_DIV_DFLT
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic capture_pin_even,
	input wire logic capture_pin_odd,
	input wire logic [31:0] rd_data,
	input wire logic trig_a,
	input wire logic trig_b,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// shadow of the software-owned settings
	typedef struct packed
	{
		logic [2:0] cfg; // configuration code last written
		logic [1:0] ote; // trigger-out enables, b then a
		logic [31:0] imr; // interrupt mask
	} gpt_shadow_s;
	gpt_shadow_s sh_reg;
	gpt_shadow_s sh_next;

	// follow bus writes; hardware never changes these fields itself
	always_comb
	begin
		sh_next = sh_reg;
		if (wr_en && addr == OFS_CFG)
			sh_next.cfg = wr_data[2:0];
		if (wr_en && addr == OFS_CTL)
			sh_next.ote = {wr_data[CTL_OTE + TB_SHIFT], wr_data[CTL_OTE]};
		if (wr_en && addr == OFS_IMR)
			sh_next.imr = wr_data;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			sh_reg <= '0;
		else
			sh_reg <= sh_next;
	end

	// ==========================================================
	// assertions; $past covers a trigger launched just before a setting changed
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	chk_read_idle: assert property (!$past(rd_en) |-> rd_data == 32'h0)
		else $error("read data not zero outside a read");
	chk_cfg_read: assert property (rd_en && addr == OFS_CFG |=>
		rd_data == {29'h0, $past(sh_reg.cfg)}) else $error("config readback wrong");
	chk_clear_read: assert property (rd_en && addr == OFS_ICR |=> rd_data == 32'h0)
		else $error("clear register reads nonzero");
	chk_ris_bits: assert property (rd_en && addr == OFS_RIS |=>
		(rd_data & ~32'h0000_030B) == 32'h0) else $error("status has stray bits");
	chk_trig_a_once: assert property (trig_a |=> !trig_a)
		else $error("trigger a longer than one cycle");
	chk_trig_b_once: assert property (trig_b |=> !trig_b)
		else $error("trigger b longer than one cycle");
	chk_trig_a_gate: assert property (trig_a |-> sh_reg.ote[0] || $past(sh_reg.ote[0]))
		else $error("trigger a while disabled");
	chk_trig_b_gate: assert property (trig_b |-> sh_reg.ote[1] || $past(sh_reg.ote[1]))
		else $error("trigger b while disabled");
	chk_b_split_only: assert property (trig_b |->
		sh_reg.cfg == CFG_SPLIT || $past(sh_reg.cfg) == CFG_SPLIT) else $error("b fired joined");
	chk_irq_masked: assert property (sh_reg.imr == 32'h0 && $past(sh_reg.imr) == 32'h0
		|-> !irq) else $error("interrupt with all masked");

	cover property (trig_a);
	cover property (trig_b);
	cover property ($rose(irq));
	cover property (sh_reg.cfg == CFG_RTC && irq);
endmodule : gpt_timer_props

bind gpt_timer gpt_timer_props #(.RTC_DIV(RTC_DIV)) u_props (.mclk(mclk), .nrst(nrst),
	.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
	.capture_pin_even(capture_pin_even), .capture_pin_odd(capture_pin_odd),
	.rd_data(rd_data), .trig_a(trig_a), .trig_b(trig_b), .irq(irq));

/* File: sim/gpt_pin_src.sv */
// far-side source of edges and of the slow reference clock on the capture pins
module gpt_pin_src
(
	input wire logic mclk,
	output logic pin_even,
	output logic pin_odd
);
	timeunit 1ns;
	timeprecision 1ps;

	// pins rest low; the reference clock stands still between bursts
	initial
	begin
		pin_even <= 1'b0;
		pin_odd <= 1'b0;
	end

	// ==========================================================
	// toggle one pin n times, gap cycles apart, on the rising edge by non-blocking assignment
	// the reference clock is scaled far above its true rate to keep runs short
	task automatic toggle(input bit odd, input int n, input int gap);
		for (int i = 0; i < n; i++)
		begin
			repeat (gap) @(posedge mclk);
			if (odd)
				pin_odd <= ~pin_odd;
			else
				pin_even <= ~pin_even;
		end
	endtask : toggle
endmodule : gpt_pin_src

/* File: sim/gpt_timer_tb.sv */
// self-checking bench for the general timer module
module gpt_timer_tb
	import gpt_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// clock, bus and pins
	localparam int DIV = 4; // short divider keeps clock-mode runs brief
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic pin_even;
	logic pin_odd;
	logic [31:0] rd_data;
	logic trig_a;
	logic trig_b;
	logic irq;
	logic [31:0] v;
	logic [7:0] pv [3];
	int err_count = 0;
	int compares = 0;
	int n;
	int c;
	int k;
	int sel;

	always #2 mclk = ~mclk;

	gpt_timer #(.RTC_DIV(DIV)) dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .capture_pin_even(pin_even), .capture_pin_odd(pin_odd),
		.rd_data(rd_data), .trig_a(trig_a), .trig_b(trig_b), .irq(irq));
	gpt_pin_src src (.mclk(mclk), .pin_even(pin_even), .pin_odd(pin_odd));

	// ==========================================================
	// helpers
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe, so sample mid-cycle there
	task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd_en <= 1'b0;
		@(negedge mclk);
		chk(what, rd_data, exp);
	endtask : rc

	// cycles until a trigger pulses; the bound keeps a dead timer from hanging us
	task automatic wt(input bit b, input int lim, output int cnt);
		cnt = 0;
		do
		begin
			@(negedge mclk);
			cnt++;
		end
		while ((b ? trig_b : trig_a) !== 1'b1 && cnt < lim);
	endtask : wt

	// clocks between time-outs: each count takes p+1, the zero state one
	function automatic int per(input int cnt, input int p);
		return cnt * (p + 1) + 1;
	endfunction : per

	// clock-mode count after t ticks with match m
	function automatic logic [31:0] rtc(input int t, input logic [31:0] m);
		logic [31:0] x;
		x = RTC_FIRST;
		repeat (t) x = (x == m) ? 32'h0 : x + 32'h1;
		return x;
	endfunction : rtc

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	// watchdog at 20000 cycles, several times the few thousand the tests need
	initial
	begin
		#80000;
		err_count++;
		$display("watchdog expired");
		wrap_up();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		void'($urandom(7));
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		rc("cnt rst", OFS_CNT_A, 32'hFFFF_FFFF);
		rc("pr rst", OFS_PR_A, 32'h0);
		rc("hole", 8'h40, 32'h0);
		$display("reset test done");
		// joined periodic: paired load, reload on rewrite, period
		wr(OFS_MODE_A, {30'h0, MODE_PERIODIC});
		v = $urandom;
		wr(OFS_ILR_A, v);
		rc("ilr32", OFS_ILR_A, v);
		rc("cnt32", OFS_CNT_A, v);
		n = 2 + $urandom % 8;
		wr(OFS_IMR, 32'h1);
		wr(OFS_CTL, 32'h21);
		wr(OFS_ILR_A, 32'(n));
		wt(0, 3000, c);
		chk("reload", 32'(c), 32'(n + 1));
		wt(0, 3000, c);
		chk("period", 32'(c), 32'(per(n, 0)));
		chk("irq", 32'(irq), 32'h1);
		rc("mis", OFS_MIS, 32'h1);
		wr(OFS_CTL, 32'h0);
		wr(OFS_ICR, 32'h1);
		rc("ris clr", OFS_RIS, 32'h0);
		rc("icr", OFS_ICR, 32'h0);
		$display("joined periodic test done");
		// joined one-shot with a stall in mid-count
		wr(OFS_MODE_A, {30'h0, MODE_ONE_SHOT});
		wr(OFS_ILR_A, 32'd300);
		wr(OFS_CTL, 32'h21);
		wr(OFS_CTL, 32'h23);
		// two counts pass before the stall lands: the cycle after enable and the write cycle
		rc("stall0", OFS_CNT_A, 32'd298);
		repeat (7) @(posedge mclk);
		rc("stall", OFS_CNT_A, 32'd298);
		wr(OFS_CTL, 32'h21);
		wt(0, 3000, c);
		chk("shot", 32'(c), 32'd299);
		wt(0, 400, c);
		chk("no retrig", 32'(c), 32'd400);
		rc("en off", OFS_CTL, 32'h20);
		rc("cnt back", OFS_CNT_A, 32'd300);
		$display("joined one-shot test done");
		// split timer b with prescale corners
		wr(OFS_CFG, 32'(CFG_SPLIT));
		rc("cfg", OFS_CFG, 32'(CFG_SPLIT));
		wr(OFS_MODE_B, {30'h0, MODE_PERIODIC});
		wr(OFS_IMR, 32'h100);
		pv = '{8'h00, 8'($urandom_range(1, 254)), 8'hFF};
		foreach (pv[i])
		begin
			n = 1 + $urandom % 3;
			wr(OFS_PR_B, {24'h0, pv[i]});
			wr(OFS_ILR_B, 32'(n));
			wr(OFS_CTL, 32'h2100);
			wt(1, 3000, c);
			wt(1, 3000, c);
			chk("prescale", 32'(c), 32'(per(n, pv[i])));
			wr(OFS_CTL, 32'h0);
		end
		// timer a's one-shot flag is still held: nothing has cleared it yet
		rc("ris b", OFS_RIS, 32'h101);
		chk("irq b", 32'(irq), 32'h1);
		wr(OFS_ICR, 32'h101);
		$display("split prescale test done");
		// edge count on both pins, every edge kind; extra edges must be ignored
		for (int e = 0; e < 3; e++)
		begin
			sel = e % 2;
			k = 1 + $urandom % 3;
			n = 6 + $urandom % 6;
			wr(8'(OFS_MODE_A + 4 * sel), {30'h0, MODE_EDGE});
			wr(8'(OFS_ILR_A + 4 * sel), 32'(n));
			wr(8'(OFS_MATCH_A + 4 * sel), 32'(n - k));
			wr(OFS_CTL, 32'(((e << 2) | 1) << (8 * sel)));
			src.toggle(sel[0], 2 * k + 2, 3 + $urandom % 4);
			repeat (6) @(negedge mclk);
			rc("edge ris", OFS_RIS, 32'(2 << (8 * sel)));
			rc("edge en", OFS_CTL, 32'(e << (2 + 8 * sel)));
			rc("edge cnt", 8'(OFS_CNT_A + 4 * sel), 32'(n));
			wr(OFS_ICR, 32'h202);
		end
		$display("edge count test done");
		// clock mode with stalls overridden, three divided ticks
		wr(OFS_CFG, 32'(CFG_RTC));
		rc("rtc first", OFS_CNT_A, RTC_FIRST);
		k = 1 + $urandom % 3;
		wr(OFS_MATCH_A, 32'(k));
		wr(OFS_IMR, 32'h8);
		wr(OFS_CTL, 32'h13);
		src.toggle(1'b0, 6 * DIV, 3);
		repeat (6) @(negedge mclk);
		rc("rtc cnt", OFS_CNT_A, rtc(3, 32'(k)));
		rc("rtc ris", OFS_RIS, 32'h8);
		chk("rtc irq", 32'(irq), 32'h1);
		wr(OFS_ICR, 32'h8);
		rc("rtc clr", OFS_RIS, 32'h0);
		$display("clock mode test done");
		wrap_up();
	end
endmodule : gpt_timer_tb
